// ===== abrg_pkg.sv
// Purpose: shared constants of the serial baud rate generator
// Assumes: register indices are word indices on APB (byte address = 4 * index)
// Notes:   field positions and reset values live here only once
package abrg_pkg;

    // register index width and word indices
    localparam int ABRG_IDX_W = 8;
    localparam logic [7:0] ABRG_IDX_STATUS = 8'h50;
    localparam logic [7:0] ABRG_IDX_DATA = 8'h51;
    localparam logic [7:0] ABRG_IDX_BAUD = 8'h52;
    localparam logic [7:0] ABRG_IDX_CTRL1 = 8'h53;
    localparam logic [7:0] ABRG_IDX_CTRL2 = 8'h54;
    localparam logic [7:0] ABRG_IDX_ERX = 8'h55;
    localparam logic [7:0] ABRG_IDX_ETX = 8'h57;
    localparam logic [7:0] ABRG_IDX_RATE_STAT = 8'h58;

    // apb address width: index plus two byte bits
    localparam int ABRG_ADDR_W = ABRG_IDX_W + 2;

    // baud control field positions
    localparam int ABRG_PRESC_MSB = 7;
    localparam int ABRG_PRESC_LSB = 6;
    localparam int ABRG_TXDIV_MSB = 5;
    localparam int ABRG_TXDIV_LSB = 3;
    localparam int ABRG_RXDIV_MSB = 2;
    localparam int ABRG_RXDIV_LSB = 0;

    // low power disable bit in control one
    localparam int ABRG_DISABLE_BIT = 5;

    // reset values
    localparam logic [7:0] ABRG_RST_STATUS = 8'hc0;
    localparam logic [7:0] ABRG_RST_ZERO = 8'h00;
    localparam logic [31:0] ABRG_RST_RDATA = 32'h0000_0000;

    // first prescaler factors per code
    localparam logic [3:0] ABRG_PR_CODE0 = 4'h1;
    localparam logic [3:0] ABRG_PR_CODE1 = 4'h3;
    localparam logic [3:0] ABRG_PR_CODE2 = 4'h4;
    localparam logic [3:0] ABRG_PR_CODE3 = 4'hd;

    // fixed oversampling stage, as a shift of four
    localparam int ABRG_OVERSAMPLE_SHIFT = 4;

    // widest period: 13 * 128 * 16 * 255 fits in 24 bits
    localparam int ABRG_PERIOD_W = 24;

endpackage

// ===== abrg_rate_div.sv
// Purpose: one free running rate counter emitting a one-cycle tick per period
// Assumes: period is stable except around a restart request
// Notes:   restart and stop both clear the count so no short tick follows
`timescale 1ns/10ps
module abrg_rate_div #(
    parameter int W = 24
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic restart,
    input wire logic [W-1:0] period,
    output logic tick
);

    // the counter needs some room and must stay within 32 bits
    if (W < 2 || W > 32) begin : g_bad_width
        $error("abrg_rate_div: W out of range");
    end

    // whole state of the counter
    typedef struct packed {
        logic [W-1:0] count; // cycles since last tick
        logic tick;          // registered tick
    } abrg_div_s;

    abrg_div_s div_reg;
    abrg_div_s div_next;

    // next state: count up to period - 1, then wrap and tick
    always_comb begin
        div_next = div_reg;
        div_next.tick = 1'b0;
        if (restart || !run) begin
            // clean restart: partial period is thrown away
            div_next.count = '0;
        end else if (div_reg.count >= period - W'(1)) begin
            div_next.count = '0;
            div_next.tick = 1'b1;
        end else begin
            div_next.count = div_reg.count + W'(1);
        end
    end

    // register the state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    assign tick = div_reg.tick;

endmodule

// ===== abrg_baud_gen.sv
// Purpose: baud rate generator of the async serial interface, APB register view
// Assumes: APB master on clk; 8-bit registers sit in the low byte of a word
// Notes:   tx and rx ticks are one-cycle pulses at the final bit rate
//
// Contract
// - prescaler code 00,01,10,11 divides 1,3,4,13
// - tx divisor code n divides by 2**n
// - rx divisor codes 1..7 divide 2..128
// - fixed divide-by-16 after prescaler and divisor
// - nonzero extended rx value divides rx further
// - nonzero extended tx value divides tx further
// - reset clears baud and extended dividers
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
module abrg_baud_gen
    import abrg_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [abrg_pkg::ABRG_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic tx_rate_tick,
    output logic rx_rate_tick,
    output logic tx_ext_active,
    output logic rx_ext_active,
    output logic rate_enabled
);
    import abrg_pkg::*;

    // all software visible state plus bus helpers
    typedef struct packed {
        logic [7:0] data;     // serial_data, write holding value
        logic [7:0] baud;     // baud_control
        logic [7:0] ctrl1;    // serial_control_one
        logic [7:0] ctrl2;    // serial_control_two
        logic [7:0] erx;      // extended_rx_divider
        logic [7:0] etx;      // extended_tx_divider
        logic [31:0] rdata;   // read data, loaded in the setup cycle
        logic restart;        // one-cycle restart of both counters
    } abrg_regs_s;

    abrg_regs_s regs_reg;
    abrg_regs_s regs_next;

    // word index of the current transfer
    logic [ABRG_IDX_W-1:0] idx;

    // decoded bus qualifiers
    logic setup_phase;
    logic access_phase;
    logic hit;
    logic wr_en;

    // periods handed to the counters
    logic [ABRG_PERIOD_W-1:0] tx_period;
    logic [ABRG_PERIOD_W-1:0] rx_period;

    // counter run enable, low while low power disable is set
    logic run;

    // decode the first prescaler code into its factor
    function automatic logic [3:0] presc_factor(input logic [1:0] code);
        logic [3:0] f;
        unique case (code)
            2'b00: f = ABRG_PR_CODE0;
            2'b01: f = ABRG_PR_CODE1;
            2'b10: f = ABRG_PR_CODE2;
            2'b11: f = ABRG_PR_CODE3;
        endcase
        return f;
    endfunction

    // power-of-two divisor; code 0 gives 1 for both directions
    function automatic logic [7:0] pow2_factor(input logic [2:0] code);
        logic [7:0] f;
        f = 8'h01 << code;
        return f;
    endfunction

    // full period in clk cycles for one direction
    function automatic logic [ABRG_PERIOD_W-1:0] rate_period(
        input logic [1:0] pcode,
        input logic [2:0] dcode,
        input logic [7:0] ext
    );
        logic [ABRG_PERIOD_W-1:0] p;
        logic [ABRG_PERIOD_W-1:0] e;
        p = ABRG_PERIOD_W'(presc_factor(pcode));
        // conventional divisor multiplies the prescaled clock
        p = ABRG_PERIOD_W'(p * ABRG_PERIOD_W'(pow2_factor(dcode)));
        // fixed oversampling stage
        p = p << ABRG_OVERSAMPLE_SHIFT;
        // extended divider acts only when nonzero
        e = (ext != ABRG_RST_ZERO) ? ABRG_PERIOD_W'(ext)
                                   : ABRG_PERIOD_W'(1);
        p = ABRG_PERIOD_W'(p * e);
        return p;
    endfunction

    // word select ignores the two byte address bits
    assign idx = paddr[ABRG_ADDR_W-1:2];

    // apb phases
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;

    // address map check
    always_comb begin
        unique case (idx)
            ABRG_IDX_STATUS,
            ABRG_IDX_DATA,
            ABRG_IDX_BAUD,
            ABRG_IDX_CTRL1,
            ABRG_IDX_CTRL2,
            ABRG_IDX_ERX,
            ABRG_IDX_ETX,
            ABRG_IDX_RATE_STAT: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // a write lands only on the completing edge of the access phase
    // and only when the low byte lane is enabled
    assign wr_en = access_phase && pwrite && hit && pstrb[0];

    // next state of the register file
    always_comb begin
        regs_next = regs_reg;
        regs_next.restart = 1'b0;

        // read data is captured in the setup cycle, so the access
        // phase can finish at once while prdata still comes from a flop
        if (setup_phase && !pwrite) begin
            regs_next.rdata = ABRG_RST_RDATA;
            unique case (idx)
                ABRG_IDX_STATUS: begin
                    // transmitter and line are always idle here
                    regs_next.rdata[7:0] = ABRG_RST_STATUS;
                end
                ABRG_IDX_DATA: begin
                    regs_next.rdata[7:0] = regs_reg.data;
                end
                ABRG_IDX_BAUD: begin
                    regs_next.rdata[7:0] = regs_reg.baud;
                end
                ABRG_IDX_CTRL1: begin
                    regs_next.rdata[7:0] = regs_reg.ctrl1;
                end
                ABRG_IDX_CTRL2: begin
                    regs_next.rdata[7:0] = regs_reg.ctrl2;
                end
                ABRG_IDX_ERX: begin
                    regs_next.rdata[7:0] = regs_reg.erx;
                end
                ABRG_IDX_ETX: begin
                    regs_next.rdata[7:0] = regs_reg.etx;
                end
                ABRG_IDX_RATE_STAT: begin
                    // live generator state
                    regs_next.rdata[0] = tx_ext_active;
                    regs_next.rdata[1] = rx_ext_active;
                    regs_next.rdata[2] = run;
                end
                default: begin
                    // unmapped reads return zero
                    regs_next.rdata = ABRG_RST_RDATA;
                end
            endcase
        end

        // register writes; status words are read only
        if (wr_en) begin
            unique case (idx)
                ABRG_IDX_DATA: begin
                    regs_next.data = pwdata[7:0];
                end
                ABRG_IDX_BAUD: begin
                    regs_next.baud = pwdata[7:0];
                    regs_next.restart = 1'b1;
                end
                ABRG_IDX_CTRL1: begin
                    regs_next.ctrl1 = pwdata[7:0];
                    // disable bit may change, start from a clean count
                    regs_next.restart = 1'b1;
                end
                ABRG_IDX_CTRL2: begin
                    regs_next.ctrl2 = pwdata[7:0];
                end
                ABRG_IDX_ERX: begin
                    regs_next.erx = pwdata[7:0];
                    regs_next.restart = 1'b1;
                end
                ABRG_IDX_ETX: begin
                    regs_next.etx = pwdata[7:0];
                    regs_next.restart = 1'b1;
                end
                default: begin
                    // read only or unmapped: nothing stored
                    regs_next.restart = regs_next.restart;
                end
            endcase
        end
    end

    // register file; all fields start at zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regs_reg.data <= ABRG_RST_ZERO;
            regs_reg.baud <= ABRG_RST_ZERO;
            regs_reg.ctrl1 <= ABRG_RST_ZERO;
            regs_reg.ctrl2 <= ABRG_RST_ZERO;
            regs_reg.erx <= ABRG_RST_ZERO;
            regs_reg.etx <= ABRG_RST_ZERO;
            regs_reg.rdata <= ABRG_RST_RDATA;
            regs_reg.restart <= 1'b0;
        end else begin
            regs_reg <= regs_next;
        end
    end

    // counters stop while the low power disable bit is set
    assign run = !regs_reg.ctrl1[ABRG_DISABLE_BIT];

    // transmit period from prescaler, tx divisor and tx extension
    assign tx_period = rate_period(
        regs_reg.baud[ABRG_PRESC_MSB:ABRG_PRESC_LSB],
        regs_reg.baud[ABRG_TXDIV_MSB:ABRG_TXDIV_LSB],
        regs_reg.etx);

    // receive period from prescaler, rx divisor and rx extension
    assign rx_period = rate_period(
        regs_reg.baud[ABRG_PRESC_MSB:ABRG_PRESC_LSB],
        regs_reg.baud[ABRG_RXDIV_MSB:ABRG_RXDIV_LSB],
        regs_reg.erx);

    // transmit rate counter
    abrg_rate_div #(
        .W(ABRG_PERIOD_W)
    ) u_tx_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(run),
        .restart(regs_reg.restart),
        .period(tx_period),
        .tick(tx_rate_tick)
    );

    // receive rate counter
    abrg_rate_div #(
        .W(ABRG_PERIOD_W)
    ) u_rx_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(run),
        .restart(regs_reg.restart),
        .period(rx_period),
        .tick(rx_rate_tick)
    );

    // extended paths are in use only with a nonzero value
    assign tx_ext_active = (regs_reg.etx != ABRG_RST_ZERO);
    assign rx_ext_active = (regs_reg.erx != ABRG_RST_ZERO);
    assign rate_enabled = run;

    // bus answers: no wait states, error only on unmapped words
    assign prdata = regs_reg.rdata;
    assign pready = 1'b1;
    assign pslverr = access_phase && !hit;

endmodule

// ===== abrg_baud_gen_sva.sv
// Purpose: bus and rate tick checks of the baud generator
// Assumes: one clock domain, async active high reset
// Notes: gap counter saturates, so long periods stay legal
`timescale 1ns/10ps
module abrg_baud_gen_sva
    import abrg_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [abrg_pkg::ABRG_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tx_rate_tick,
    input wire logic rx_rate_tick,
    input wire logic tx_ext_active,
    input wire logic rx_ext_active,
    input wire logic rate_enabled
);
    logic [11:0] gap_reg; // cycles since the last tx tick
    logic [11:0] gap_next;
    logic [7:0] idx;
    logic acc; // access phase
    logic mapped;
    assign idx = paddr[ABRG_ADDR_W-1:2];
    assign acc = psel && penable;
    assign mapped = idx inside {[ABRG_IDX_STATUS:ABRG_IDX_ERX], ABRG_IDX_ETX, ABRG_IDX_RATE_STAT};
    // gap starts at one on a tick so it equals the period when the next tick shows
    always_comb begin
        gap_next = tx_rate_tick ? 12'h001 : ((&gap_reg) ? gap_reg : gap_reg + 12'h001);
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap_reg <= 12'h000;
        end else begin
            gap_reg <= gap_next;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence wr_acc(logic [7:0] i);
        acc && pwrite && pstrb[0] && idx == i;
    endsequence
    bus_ready_a: assert property (pready)
        else $error("pready low");
    err_unmapped_a: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    err_quiet_a: assert property (!(acc && !mapped) |-> !pslverr)
        else $error("spurious pslverr");
    rx_ext_a: assert property (wr_acc(ABRG_IDX_ERX) |=> rx_ext_active == (|$past(pwdata[7:0])))
        else $error("rx extended flag wrong");
    tx_ext_a: assert property (wr_acc(ABRG_IDX_ETX) |=> tx_ext_active == (|$past(pwdata[7:0])))
        else $error("tx extended flag wrong");
    en_follow_a: assert property (wr_acc(ABRG_IDX_CTRL1) |=> rate_enabled == !$past(pwdata[5]))
        else $error("enable does not follow write");
    tx_pulse_a: assert property (tx_rate_tick |=> !tx_rate_tick)
        else $error("tx tick longer than one cycle");
    rx_pulse_a: assert property (rx_rate_tick |=> !rx_rate_tick)
        else $error("rx tick longer than one cycle");
    tx_gap_a: assert property (tx_rate_tick |-> gap_reg >= 12'd16)
        else $error("tx ticks closer than sixteen cycles");
    halt_ticks_a: assert property (!rate_enabled ##1 !rate_enabled |-> !tx_rate_tick && !rx_rate_tick)
        else $error("tick while disabled");
endmodule
bind abrg_baud_gen abrg_baud_gen_sva u_sva (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_rate_tick(tx_rate_tick),
    .rx_rate_tick(rx_rate_tick), .tx_ext_active(tx_ext_active),
    .rx_ext_active(rx_ext_active), .rate_enabled(rate_enabled));

// ===== abrg_tick_peer.sv
// Purpose: far side model, samples the rate ticks like a remote serial peer
// Assumes: ticks are one-cycle pulses on clk
// Notes: reports the spacing of the last two ticks and a running count
`timescale 1ns/10ps
module abrg_tick_peer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tx_rate_tick,
    input wire logic rx_rate_tick,
    output logic [23:0] tx_period,
    output logic [23:0] rx_period,
    output int tx_n,
    output int rx_n
);
    logic [23:0] tx_age, rx_age; // cycles since each tick
    // age equals the period at the tick itself
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {tx_age, rx_age, tx_period, rx_period} <= '0;
            tx_n <= 0;
            rx_n <= 0;
        end else begin
            tx_age <= tx_rate_tick ? 24'h000001 : tx_age + 24'h000001;
            rx_age <= rx_rate_tick ? 24'h000001 : rx_age + 24'h000001;
            if (tx_rate_tick) begin
                tx_period <= tx_age;
                tx_n <= tx_n + 1;
            end
            if (rx_rate_tick) begin
                rx_period <= rx_age;
                rx_n <= rx_n + 1;
            end
        end
    end
endmodule

// ===== abrg_baud_gen_tb.sv
// Purpose: self-checking bench of the baud rate generator
// Assumes: zero wait APB slave; the peer measures tick spacing
// Notes: periods are judged on the third tick after a write, past any restart
`timescale 1ns/10ps
module abrg_baud_gen_tb;
    import abrg_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ABRG_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = '0;
    logic pready, pslverr, tx_rate_tick, rx_rate_tick, txe, rxe, ren, er;
    logic [23:0] tx_period, rx_period;
    int tx_n, rx_n, err_total = 0, n_compared = 0, cycles = 0;
    int prf[4] = '{1, 3, 4, 13}; // prescaler factor per code
    abrg_baud_gen u_abrg_baud_gen (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_rate_tick(tx_rate_tick),
        .rx_rate_tick(rx_rate_tick), .tx_ext_active(txe), .rx_ext_active(rxe),
        .rate_enabled(ren));
    abrg_tick_peer u_abrg_tick_peer (.clk(clk), .sys_rst(sys_rst), .tx_rate_tick(tx_rate_tick),
        .rx_rate_tick(rx_rate_tick), .tx_period(tx_period), .rx_period(rx_period),
        .tx_n(tx_n), .rx_n(rx_n));
    initial forever #25 clk = ~clk;
    // the run needs about 26k cycles; a hang ends the run here
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compared %0d wrong %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
        input logic [3:0] st);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        pstrb <= st;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] v);
        xfer(1'b1, idx, v, 4'hf);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp, input logic eerr);
        xfer(1'b0, idx, 32'h0, 4'h0);
        check("read data", exp, rd);
        check("slave error", {31'h0, eerr}, {31'h0, er});
    endtask
    // wait out any restart, then judge the spacing of settled ticks
    task automatic rates(input int tp, input int rp);
        int t0;
        int r0;
        t0 = tx_n;
        r0 = rx_n;
        while (tx_n < t0 + 3 || rx_n < r0 + 3) @(posedge clk);
        check("tx period", tp, {8'h0, tx_period});
        check("rx period", rp, {8'h0, rx_period});
    endtask
    task automatic t_reset();
        logic [7:0] ix[6] = '{ABRG_IDX_STATUS, ABRG_IDX_BAUD, ABRG_IDX_CTRL2, ABRG_IDX_ERX,
            ABRG_IDX_ETX, 8'h56};
        for (int i = 0; i < 6; i++) begin
            rdchk(ix[i], (i == 0) ? 32'h0000_00c0 : 32'h0, i == 5);
        end
        check("ext flags", 32'h1, {29'h0, txe, rxe, ren});
        rates(16, 16);
    endtask
    task automatic t_codes();
        for (int c = 0; c < 4; c++) begin
            wr(ABRG_IDX_BAUD, 32'(c << 6));
            rates(16 * prf[c], 16 * prf[c]);
        end
        for (int n = 0; n < 8; n++) begin
            wr(ABRG_IDX_BAUD, 32'(n * 9));
            rates(16 << n, 16 << n);
        end
    endtask
    task automatic t_ext();
        wr(ABRG_IDX_BAUD, 32'h08);
        wr(ABRG_IDX_ETX, 32'h05);
        wr(ABRG_IDX_ERX, 32'hff);
        rdchk(ABRG_IDX_ERX, 32'hff, 1'b0);
        check("ext flags", 32'h7, {29'h0, txe, rxe, ren});
        rates(160, 4080);
        wr(ABRG_IDX_ETX, 32'h00);
        wr(ABRG_IDX_ERX, 32'h00);
        // the last write lands at the edge the task returned on
        @(posedge clk);
        check("ext flags", 32'h1, {29'h0, txe, rxe, ren});
        rates(32, 16);
    endtask
    task automatic t_refuse();
        int t0;
        xfer(1'b1, ABRG_IDX_BAUD, 32'h3f, 4'h0);
        rdchk(ABRG_IDX_BAUD, 32'h08, 1'b0);
        wr(ABRG_IDX_STATUS, 32'h00);
        rdchk(ABRG_IDX_STATUS, 32'hc0, 1'b0);
        wr(8'h56, 32'h11);
        check("unmapped write error", 32'h1, {31'h0, er});
        wr(ABRG_IDX_CTRL1, 32'h20);
        // a tick already in flight at the write edge may still be counted
        repeat (3) @(posedge clk);
        t0 = tx_n + rx_n;
        repeat (300) @(posedge clk);
        check("ticks while disabled", t0, tx_n + rx_n);
        check("enable", 32'h0, {31'h0, ren});
        wr(ABRG_IDX_CTRL1, 32'h00);
        rates(32, 16);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_codes();
        t_ext();
        t_refuse();
        print_verdict();
    end
endmodule
